// *** inc/cpg_pkg.sv ***
// Package holding constants, types and the register map of the counter PWM/FM generator.
package cpg_pkg;

    // Channel count and counter width.
    localparam int NUM_CHAN          = 5;
    localparam int CNT_W             = 16;

    // Clock and timebase figures.
    localparam int CLOCK_HZ          = 10_000_000;
    localparam int SOURCE_OSC_HZ     = 1_000_000;
    localparam int SOURCE_OSC_DIV    = CLOCK_HZ / SOURCE_OSC_HZ;
    localparam int DECADE            = 10;

    // Timebase select codes.
    localparam logic [2:0] TB_ONE_MEGAHERTZ     = 3'h0;
    localparam logic [2:0] TB_HUNDRED_KILOHERTZ = 3'h1;
    localparam logic [2:0] TB_TEN_KILOHERTZ     = 3'h2;
    localparam logic [2:0] TB_ONE_KILOHERTZ     = 3'h3;
    localparam logic [2:0] TB_HUNDRED_HERTZ     = 3'h4;

    // Register byte offsets; each channel takes a block of four words.
    localparam logic [7:0] REG_GLOBAL        = 8'h00;
    localparam logic [7:0] REG_CHAN_BASE     = 8'h10;
    localparam logic [7:0] REG_CHAN_STRIDE   = 8'h10;
    localparam logic [3:0] REG_CTRL          = 4'h0;
    localparam logic [3:0] REG_PERIOD        = 4'h4;
    localparam logic [3:0] REG_DUTY          = 4'h8;
    localparam logic [3:0] REG_STATUS        = 4'hc;

    // Control field positions.
    localparam int CTRL_ENABLE       = 0;
    localparam int CTRL_MODE_FREQ    = 1;
    localparam int CTRL_ARM_USE      = 2;
    localparam int CTRL_ARM          = 3;
    localparam int CTRL_TOGGLE_HIGH  = 4;
    localparam int CTRL_TB_LSB       = 8;
    localparam int GLOBAL_OSC_5MHZ   = 0;

    // Reset values.
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [15:0] DUTY_RESET   = 16'h0000;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Channel setting carried from the register file to one generator.
    typedef struct packed {
        logic        enable;
        logic        arm;
        logic        toggle_high;
        logic [2:0]  timebase_select;
        logic [15:0] period;
        logic [15:0] duty;
        logic        load;
    } cpg_chan_cfg_t;

    // Channel state returned for reading.
    typedef struct packed {
        logic        running;
        logic        level;
        logic [15:0] count;
    } cpg_chan_sts_t;

endpackage

// *** tb/cpg_host_model.sv ***
// Register master standing in for the host driver on the register port.
`timescale 1ns/10ps
module cpg_host_model
    import cpg_pkg::*;
#(
    parameter logic [7:0] BOARD_IO_ORIGIN = 8'h00
) (
    input  wire logic        clk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    logic slow = 1'b0;

    // Idle levels from time zero.
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hf;
    end

    // One write; ready for the response only once it shows when slow is set.
    task automatic wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rr);
        logic ta, tw, tv, th;
        awaddr  <= BOARD_IO_ORIGIN + a;
        wdata   <= dd;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= !slow;
        {tv, th} = 2'b00;
        while (!(tv && th)) begin
            @(negedge clk);
            {ta, tw, tv, th, rr} = {awready && awvalid, wready && wvalid, bvalid, bready, bresp};
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tv && !th) bready <= 1'b1;
        end
        bready <= 1'b0;
        // Let one edge pass so that a following call never drives bready in this step.
        @(posedge clk);
    endtask

    // One read, with the same late-ready option.
    task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rr);
        logic ta, tv, th;
        araddr  <= BOARD_IO_ORIGIN + a;
        arvalid <= 1'b1;
        rready  <= !slow;
        {tv, th} = 2'b00;
        while (!(tv && th)) begin
            @(negedge clk);
            {ta, tv, th, rr, dd} = {arready && arvalid, rvalid, rready, rresp, rdata};
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tv && !th) rready <= 1'b1;
        end
        rready <= 1'b0;
        // Let one edge pass so that a following call never drives rready in this step.
        @(posedge clk);
    endtask
endmodule // cpg_host_model

// *** tb/cpg_top_sva.sv ***
// Checker for the register port of the generator.
`timescale 1ns/10ps
module cpg_top_sva
    import cpg_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        ARST_N,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [7:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY
);
    // All checks share the one clock and stand down in reset.
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!ARST_N);

    a_write_resp: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID
    ) else $error("Write response late.");
    a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("Write response dropped.");
    a_bvalid_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
        !S_AXI_BVALID) else $error("Write response repeated.");
    a_aw_blocked: assert property (S_AXI_BVALID |->
        !S_AXI_AWREADY && !S_AXI_WREADY) else $error("Write taken during response.");
    a_read_resp: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
        S_AXI_RVALID) else $error("Read response late.");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("Read data dropped.");
    a_ar_blocked: assert property (S_AXI_RVALID |->
        !S_AXI_ARREADY) else $error("Read taken during response.");
    a_rd_unmapped: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h08 |=>
        S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("Unmapped read ok.");
endmodule // cpg_top_sva

bind cpg_top cpg_top_sva u_sva (.CLOCK, .ARST_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);

// *** tb/testbench.sv ***
// Self-checking bench for the five-channel generator.
`timescale 1ns/10ps
module testbench
    import cpg_pkg::*;
;
    logic        CLOCK = 1'b0;
    logic        ARST_N = 1'b0;
    logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
    logic [3:0]  S_AXI_WSTRB;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
    logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
    logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic [4:0]  WAVE_OUT;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          k;

    // Clock of 100 ns period.
    always #50 CLOCK = ~CLOCK;

    cpg_top #(.N(5)) u_dut (.CLOCK, .ARST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
        .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
        .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .WAVE_OUT);

    cpg_host_model u_host (.clk(CLOCK), .awaddr(S_AXI_AWADDR), .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY), .wdata(S_AXI_WDATA), .wstrb(S_AXI_WSTRB),
        .wvalid(S_AXI_WVALID), .wready(S_AXI_WREADY), .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID), .bready(S_AXI_BREADY), .araddr(S_AXI_ARADDR),
        .arvalid(S_AXI_ARVALID), .arready(S_AXI_ARREADY), .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP), .rvalid(S_AXI_RVALID), .rready(S_AXI_RREADY));

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compares one value and reports a difference.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Byte address of a register in the block of channel c (0 is channel 1).
    function automatic logic [7:0] ca(input int c, input logic [3:0] o);
        return REG_CHAN_BASE + REG_CHAN_STRIDE * c[7:0] + {4'h0, o};
    endfunction

    // Waits s clocks, then counts high clocks of one output over w clocks.
    task automatic hi(input int c, input int w, input int s);
        k = 0;
        repeat (s) @(posedge CLOCK);
        repeat (w) begin
            @(negedge CLOCK);
            k += int'(WAVE_OUT[c] === 1'b1);
        end
        @(posedge CLOCK);
    endtask

    // Skips two changes of channel 2's output, then times the next gap.
    task automatic gap();
        logic v;
        repeat (2) @(WAVE_OUT[1]);
        @(negedge CLOCK);
        v = WAVE_OUT[1];
        k = 0;
        while (WAVE_OUT[1] === v) begin
            @(negedge CLOCK);
            k++;
        end
        @(posedge CLOCK);
    endtask

    // Reset values, unmapped places, late ready on responses.
    task automatic t_regs();
        u_host.slow = 1'b1;
        u_host.rd(ca(0, REG_CTRL), d, r);
        chk("ctrl reset", CTRL_RESET, d);
        u_host.rd(ca(4, REG_PERIOD), d, r);
        chk("period reset", {16'h0, PERIOD_RESET}, d);
        u_host.rd(8'h08, d, r);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        u_host.wr(8'h04, 32'h1, r);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        u_host.slow = 1'b0;
        $display("register test done");
    endtask

    // Channel 1 pulse width: duty update, toggle level, oscillator select.
    task automatic t_pwm();
        u_host.wr(ca(0, REG_PERIOD), 32'h4, r);
        u_host.wr(ca(0, REG_DUTY), 32'h1, r);
        u_host.wr(ca(0, REG_CTRL), 32'h11, r);
        hi(0, 400, 80);
        chk("pwm first duty", 100, k);
        u_host.wr(ca(0, REG_DUTY), 32'h3, r);
        hi(0, 400, 80);
        chk("pwm new duty", 300, k);
        u_host.wr(ca(0, REG_CTRL), 32'h01, r);
        hi(0, 400, 80);
        chk("pwm low start", 100, k);
        u_host.wr(REG_GLOBAL, 32'h1, r);
        hi(0, 200, 20);
        chk("stopped by 5 MHz", 0, k);
        u_host.wr(REG_GLOBAL, 32'h0, r);
        $display("pulse width test done");
    endtask

    // Channel 2 tick spacing for the first four decade timebases, 1MHz to 1kHz.
    task automatic t_tb();
        u_host.wr(ca(1, REG_PERIOD), 32'h2, r);
        u_host.wr(ca(1, REG_DUTY), 32'h1, r);
        for (int c = 0; c < 4; c++) begin
            u_host.wr(ca(1, REG_CTRL), {21'h0, c[2:0], 8'h01}, r);
            gap();
            chk("tick gap", 10 ** (c + 1), k);
        end
        $display("timebase test done");
    endtask

    // Channel 3 frequency mode: initial rate, then a retune at fixed duty.
    task automatic t_freq();
        u_host.wr(ca(2, REG_PERIOD), 32'h5, r);
        u_host.wr(ca(2, REG_DUTY), 32'h2, r);
        u_host.wr(ca(2, REG_CTRL), 32'h13, r);
        hi(2, 500, 100);
        chk("fm initial", 200, k);
        u_host.wr(ca(2, REG_PERIOD), 32'ha, r);
        u_host.wr(ca(2, REG_DUTY), 32'h4, r);
        hi(2, 1000, 200);
        chk("fm retuned", 400, k);
        $display("frequency test done");
    endtask

    // Channel 5 with arm control: held, armed, held again.
    task automatic t_arm();
        u_host.wr(ca(4, REG_PERIOD), 32'h4, r);
        u_host.wr(ca(4, REG_DUTY), 32'h1, r);
        u_host.wr(ca(4, REG_CTRL), 32'h15, r);
        hi(4, 200, 20);
        chk("disarmed hold", 200, k);
        u_host.rd(ca(4, REG_STATUS), d, r);
        chk("disarmed status", 32'h0001_0000, d);
        u_host.wr(ca(4, REG_CTRL), 32'h1d, r);
        hi(4, 400, 80);
        chk("armed wave", 100, k);
        u_host.wr(ca(4, REG_CTRL), 32'h15, r);
        hi(4, 200, 20);
        chk("disarmed again", 200, k);
        $display("arm test done");
    endtask

    // Main sequence after an 8-cycle reset.
    initial begin
        repeat (8) @(posedge CLOCK);
        ARST_N <= 1'b1;
        @(posedge CLOCK);
        t_regs();
        t_pwm();
        t_tb();
        t_freq();
        t_arm();
        give_verdict();
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (60000) @(posedge CLOCK);
        n_mismatch++;
        give_verdict();
    end
endmodule // testbench

// *** verilog/cpg_channel.sv ***
// One 16-bit square-wave generator channel.
`timescale 1ns/10ps
module cpg_channel
    import cpg_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic [4:0]    tick,
    input  wire cpg_chan_cfg_t cfg,
    output cpg_chan_sts_t      sts,
    output logic               wave
);

    logic [15:0] count_r,  count_nxt;
    logic [15:0] period_r, period_nxt;
    logic [15:0] duty_r,   duty_nxt;
    logic        pend_r,   pend_nxt;
    logic        wave_r,   wave_nxt;
    logic        step;
    logic        run;

    // Selected timebase tick and run condition.
    assign step = (cfg.timebase_select < 3'h5) ? tick[cfg.timebase_select] : 1'b0;
    assign run  = cfg.enable & cfg.arm;

    // Count through the period; while running, swap in new values only at the boundary.
    always_comb begin
        count_nxt  = count_r;
        period_nxt = period_r;
        duty_nxt   = duty_r;
        pend_nxt   = pend_r | cfg.load;
        wave_nxt   = wave_r;
        if (!run) begin
            count_nxt  = 16'h0000;
            period_nxt = cfg.period;
            duty_nxt   = cfg.duty;
            pend_nxt   = 1'b0;
            wave_nxt   = cfg.toggle_high;
        end else if (step) begin
            if (count_r + 16'h0001 >= period_r) begin
                count_nxt = 16'h0000;
                if (pend_r | cfg.load) begin
                    period_nxt = cfg.period;
                    duty_nxt   = cfg.duty;
                    pend_nxt   = 1'b0;
                end
            end else begin
                count_nxt = count_r + 16'h0001;
            end
            // First duty counts at the toggle level, the rest opposite.
            wave_nxt = (count_nxt < duty_nxt) ? cfg.toggle_high : ~cfg.toggle_high;
        end
    end

    // Channel state registers.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r  <= 16'h0000;
            period_r <= PERIOD_RESET;
            duty_r   <= DUTY_RESET;
            pend_r   <= 1'b0;
            wave_r   <= 1'b0;
        end else begin
            count_r  <= count_nxt;
            period_r <= period_nxt;
            duty_r   <= duty_nxt;
            pend_r   <= pend_nxt;
            wave_r   <= wave_nxt;
        end
    end

    assign wave        = wave_r;
    assign sts.running = run;
    assign sts.level   = wave_r;
    assign sts.count   = count_r;

endmodule // cpg_channel

// *** verilog/cpg_top.sv ***
// Five-channel counter PWM/FM generator with an AXI4-Lite register slave.
`timescale 1ns/10ps
// Function
// - Five independent 16-bit square-wave channels.
// - Pulse-width mode: fixed frequency, duty varies.
// - Five decade timebases, 1MHz to 100Hz.
// - Timebases from 1MHz oscillator; 5MHz unsupported.
// - Output frequency is timebase divided by period count.
// - Pulse-width channel starts with its initial duty.
// - Period starts at toggle level for duty.
// - Arm input below half disarms, else arms.
// - Channel starts armed or disarmed as configured.
// - Frequency mode: period follows run-time input.
// - Frequency mode starts at initial relative frequency.
// - Frequency mode duty fixed at configuration; the logic takes each new duty count, and the host rescales it with the period.
module cpg_top
    import cpg_pkg::*;
#(
    parameter int N = NUM_CHAN
) (
    input  wire logic        CLOCK,
    input  wire logic        ARST_N,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic [N-1:0]     WAVE_OUT
);

    // Decode a byte address into its channel index; index N means global.
    function automatic logic [3:0] chan_of(input logic [7:0] a);
        chan_of = (a < REG_CHAN_BASE) ? 4'(N) : 4'((a - REG_CHAN_BASE) >> 4);
    endfunction

    // Merge write data into a word under byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                old[8*b +: 8] = d[8*b +: 8];
            end
        end
        merge = old;
    endfunction

    // Timebase dividers: a 1 MHz tick from the clock, then four decade stages.
    logic [3:0]  osc_cnt_r, osc_cnt_nxt;
    logic [3:0]  dec_cnt_r [4], dec_cnt_nxt [4];
    logic [4:0]  tick;
    logic        osc_5mhz_r, osc_5mhz_nxt;

    always_comb begin
        osc_cnt_nxt = (osc_cnt_r == 4'(SOURCE_OSC_DIV - 1)) ? 4'h0 : osc_cnt_r + 4'h1;
        tick[0]     = (osc_cnt_r == 4'(SOURCE_OSC_DIV - 1));
        for (int i = 0; i < 4; i++) begin
            dec_cnt_nxt[i] = dec_cnt_r[i];
            if (tick[i]) begin
                dec_cnt_nxt[i] = (dec_cnt_r[i] == 4'(DECADE - 1)) ? 4'h0 : dec_cnt_r[i] + 4'h1;
            end
            tick[i+1] = tick[i] & (dec_cnt_r[i] == 4'(DECADE - 1));
        end
    end

    // Divider counter registers.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            osc_cnt_r <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                dec_cnt_r[i] <= 4'h0;
            end
        end else begin
            osc_cnt_r <= osc_cnt_nxt;
            for (int i = 0; i < 4; i++) begin
                dec_cnt_r[i] <= dec_cnt_nxt[i];
            end
        end
    end

    // Register file and AXI4-Lite slave state.
    logic [31:0] ctrl_r   [N], ctrl_nxt   [N];
    logic [15:0] period_r [N], period_nxt [N];
    logic [15:0] duty_r   [N], duty_nxt   [N];
    logic [N-1:0] load_nxt, load_r;
    logic        aw_hold_r, aw_hold_nxt;
    logic [7:0]  aw_addr_r, aw_addr_nxt;
    logic        w_hold_r,  w_hold_nxt;
    logic [31:0] w_data_r,  w_data_nxt;
    logic [3:0]  w_strb_r,  w_strb_nxt;
    logic        bvalid_r,  bvalid_nxt;
    logic [1:0]  bresp_r,   bresp_nxt;
    logic        rvalid_r,  rvalid_nxt;
    logic [1:0]  rresp_r,   rresp_nxt;
    logic [31:0] rdata_r,   rdata_nxt;
    logic        do_write;
    logic [3:0]  wch, rch;
    logic [3:0]  wreg, rreg;
    // Merged write word; a named word because a function result takes no select.
    logic [31:0] w_word;
    cpg_chan_cfg_t cfg [N];
    cpg_chan_sts_t sts [N];

    // Address and data are each taken once and held until the response is sent.
    assign S_AXI_AWREADY = ~aw_hold_r & ~bvalid_r;
    assign S_AXI_WREADY  = ~w_hold_r & ~bvalid_r;
    assign S_AXI_ARREADY = ~rvalid_r;
    assign do_write      = aw_hold_r & w_hold_r & ~bvalid_r;
    assign wch           = chan_of(aw_addr_r);
    assign wreg          = aw_addr_r[3:0];
    assign rch           = chan_of(S_AXI_ARADDR);
    assign rreg          = S_AXI_ARADDR[3:0];

    // Write path, register updates and read path.
    always_comb begin
        aw_hold_nxt  = aw_hold_r;
        aw_addr_nxt  = aw_addr_r;
        w_hold_nxt   = w_hold_r;
        w_data_nxt   = w_data_r;
        w_strb_nxt   = w_strb_r;
        bvalid_nxt   = bvalid_r;
        bresp_nxt    = bresp_r;
        rvalid_nxt   = rvalid_r;
        rresp_nxt    = rresp_r;
        rdata_nxt    = rdata_r;
        osc_5mhz_nxt = osc_5mhz_r;
        load_nxt     = '0;
        w_word       = 32'h0000_0000;
        for (int c = 0; c < N; c++) begin
            ctrl_nxt[c]   = ctrl_r[c];
            period_nxt[c] = period_r[c];
            duty_nxt[c]   = duty_r[c];
        end
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_nxt = 1'b1;
            aw_addr_nxt = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_nxt = 1'b1;
            w_data_nxt = S_AXI_WDATA;
            w_strb_nxt = S_AXI_WSTRB;
        end
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = RESP_OKAY;
            if (aw_addr_r == REG_GLOBAL) begin
                w_word = merge({31'h0, osc_5mhz_r}, w_data_r, w_strb_r);
                osc_5mhz_nxt = w_word[GLOBAL_OSC_5MHZ];
            end else if (wch < 4'(N) && wreg == REG_CTRL && aw_addr_r[1:0] == 2'h0) begin
                ctrl_nxt[wch[2:0]] = merge(ctrl_r[wch[2:0]], w_data_r, w_strb_r);
            end else if (wch < 4'(N) && wreg == REG_PERIOD) begin
                w_word = merge({16'h0, period_r[wch[2:0]]}, w_data_r, w_strb_r);
                period_nxt[wch[2:0]] = w_word[15:0];
                load_nxt[wch[2:0]]   = 1'b1;
            end else if (wch < 4'(N) && wreg == REG_DUTY) begin
                w_word = merge({16'h0, duty_r[wch[2:0]]}, w_data_r, w_strb_r);
                duty_nxt[wch[2:0]] = w_word[15:0];
                load_nxt[wch[2:0]] = 1'b1;
            end else begin
                bresp_nxt = RESP_SLVERR;
            end
        end
        if (bvalid_r && S_AXI_BREADY) begin
            bvalid_nxt = 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            if (S_AXI_ARADDR == REG_GLOBAL) begin
                rdata_nxt = {31'h0, osc_5mhz_r};
            end else if (rch < 4'(N) && rreg == REG_CTRL) begin
                rdata_nxt = ctrl_r[rch[2:0]];
            end else if (rch < 4'(N) && rreg == REG_PERIOD) begin
                rdata_nxt = {16'h0, period_r[rch[2:0]]};
            end else if (rch < 4'(N) && rreg == REG_DUTY) begin
                rdata_nxt = {16'h0, duty_r[rch[2:0]]};
            end else if (rch < 4'(N) && rreg == REG_STATUS) begin
                rdata_nxt = {14'h0, sts[rch[2:0]].running, sts[rch[2:0]].level,
                             sts[rch[2:0]].count};
            end else begin
                rresp_nxt = RESP_SLVERR;
            end
        end else if (rvalid_r && S_AXI_RREADY) begin
            rvalid_nxt = 1'b0;
        end
    end

    // Register file and bus response registers.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_hold_r  <= 1'b0;
            aw_addr_r  <= 8'h00;
            w_hold_r   <= 1'b0;
            w_data_r   <= 32'h0000_0000;
            w_strb_r   <= 4'h0;
            bvalid_r   <= 1'b0;
            bresp_r    <= RESP_OKAY;
            rvalid_r   <= 1'b0;
            rresp_r    <= RESP_OKAY;
            rdata_r    <= 32'h0000_0000;
            osc_5mhz_r <= 1'b0;
            load_r     <= '0;
            for (int c = 0; c < N; c++) begin
                ctrl_r[c]   <= CTRL_RESET;
                period_r[c] <= PERIOD_RESET;
                duty_r[c]   <= DUTY_RESET;
            end
        end else begin
            aw_hold_r  <= aw_hold_nxt;
            aw_addr_r  <= aw_addr_nxt;
            w_hold_r   <= w_hold_nxt;
            w_data_r   <= w_data_nxt;
            w_strb_r   <= w_strb_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            rvalid_r   <= rvalid_nxt;
            rresp_r    <= rresp_nxt;
            rdata_r    <= rdata_nxt;
            osc_5mhz_r <= osc_5mhz_nxt;
            load_r     <= load_nxt;
            for (int c = 0; c < N; c++) begin
                ctrl_r[c]   <= ctrl_nxt[c];
                period_r[c] <= period_nxt[c];
                duty_r[c]   <= duty_nxt[c];
            end
        end
    end

    // Bus responses come straight from their registers.
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP  = bresp_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RRESP  = rresp_r;
    assign S_AXI_RDATA  = rdata_r;

    // Channel generators; a 5 MHz source setting keeps every channel stopped.
    for (genvar c = 0; c < N; c++) begin : g_chan
        assign cfg[c].enable          = ctrl_r[c][CTRL_ENABLE] & ~osc_5mhz_r;
        assign cfg[c].arm             = ~ctrl_r[c][CTRL_ARM_USE] | ctrl_r[c][CTRL_ARM];
        assign cfg[c].toggle_high     = ctrl_r[c][CTRL_TOGGLE_HIGH];
        assign cfg[c].timebase_select = ctrl_r[c][CTRL_TB_LSB +: 3];
        assign cfg[c].period          = period_r[c];
        // In frequency mode the host rescales the duty count with each new period,
        // so the duty fraction stays fixed while the frequency moves.
        assign cfg[c].duty            = duty_r[c];
        assign cfg[c].load            = load_r[c];
        cpg_channel u_chan (
            .clk    (CLOCK),
            .arst_n (ARST_N),
            .tick   (tick),
            .cfg    (cfg[c]),
            .sts    (sts[c]),
            .wave   (WAVE_OUT[c])
        );
    end

endmodule // cpg_top
